// *** logic/rsq_top.sv ***
// Purpose: event status, enables, output/error queues, input buffer and flow control
// Assumes: 200 MHz pclk, inputs synchronous, firmware drives commands over APB
// Notes on behaviour
// - status read returns value then clears it
// - enable mask read leaves it unchanged
// - query answers rendered as decimal digits
// - output queue holds 250 chars, read removes
// - empty output queue gives host nothing
// - message-available bit follows queue non-empty
// - errors queued, fetch returns and removes front
// - fetch on empty error queue returns zero
// - error queue emptied at reset and clear-status
// - keep first 15, then overflow, drop rest
// - received bytes enter 250-entry input FIFO
// - end-of-message mark stored as separate entry
// - full buffer holds not-ready-for-data asserted
// - buffer emptied at reset and device clear
// - send Xoff at 80%, Xon below 40%
// - clear-status zeroes status, error queue, request, completion pendings
// - status enable write loads, query returns it
// - service enable write loads, query returns it
// - operation-complete sets status bit 0 when idle
// - completion query queues 1 when idle
// - wait holds later commands until idle
// - reset command restores state, holds commands
// - command error sets bit 5 and logs
// - enabled status bit sets summary bit
// - service request line follows request bit
`default_nettype none
module rsq_top
  import rsq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire rsq_pkg::rsq_apb_req_t apb_i,
  output var rsq_pkg::rsq_apb_rsp_t apb_o,
  input wire logic in_valid, // byte from the controller
  input wire logic [7:0] in_data,
  input wire logic in_eoi, // byte ends a message
  output logic in_ready,
  output logic nrfd, // high while holding off the bus
  input wire logic dev_clear, // device clear pulse
  output logic ser_tx_valid, // flow character request
  output logic [7:0] ser_tx_char,
  input wire logic ser_tx_ready,
  output logic out_valid, // host read side of output queue
  output logic [7:0] out_data,
  input wire logic out_ready,
  input wire logic err_valid, // error report pulse
  input wire logic [1:0] err_class,
  input wire logic [15:0] err_code,
  input wire logic ops_busy, // device operations outstanding
  input wire logic spoll, // serial poll pulse
  output logic cmd_hold, // later commands must wait
  output logic rst_req, // instrument reset in progress
  input wire logic rst_done,
  output logic srq,
  output logic [7:0] stb_o // serial poll status byte
);
  import rsq_pkg::*;

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  rsq_st_t st_reg; // all state
  rsq_st_t st_next;
  logic acc; // access phase
  logic rd_esr, rd_fault, rd_inbuf, wr_cmd, wr_outq; // decoded accesses
  logic [31:0] wcmd;
  logic esb, mav, mss;
  logic ib_full, ib_push, ib_pop;
  logic [8:0] ib_ent;
  logic oq_full, oq_push, oq_pop, opcq_fire;
  logic [7:0] oq_ch;
  logic [4:0] eq_a; // error count after removal
  logic [15:0] ev; // status events this cycle
  logic [15:0] esr_clr;
  logic any_clr; // clear-status or reset command
  logic [15:0] pw;

  // power of ten for digit index, most significant first
  function automatic logic [15:0] pow10(input logic [2:0] i);
    case (i)
      3'h0: pow10 = 16'h2710;
      3'h1: pow10 = 16'h03E8;
      3'h2: pow10 = 16'h0064;
      3'h3: pow10 = 16'h000A;
      default: pow10 = 16'h0001;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // status byte and handshakes
  // ----------------------------------------------------------------
  assign mav = (st_reg.oq_cnt != 8'h00);
  assign esb = |(st_reg.esr[7:0] & st_reg.ese);
  // summary only looks at the bits that exist in this byte
  assign mss = (mav & st_reg.sre[`RSQ_S_MAV]) | (esb & st_reg.sre[`RSQ_S_ESB]);
  always_comb begin : stb_build
    stb_o = 8'h00;
    stb_o[`RSQ_S_MAV] = mav;
    stb_o[`RSQ_S_ESB] = esb;
    stb_o[`RSQ_S_RQS] = st_reg.rqs;
  end
  assign srq = st_reg.rqs;
  assign ib_full = (st_reg.ib_cnt == `RSQ_QDEPTH);
  assign in_ready = ~ib_full & ~st_reg.eoi_pend;
  assign nrfd = ib_full;
  assign out_valid = mav;
  assign out_data = st_reg.oq[st_reg.oq_rd];
  assign cmd_hold = st_reg.wai_pend | st_reg.rst_pend;
  assign rst_req = st_reg.rst_pend;
  assign oq_full = (st_reg.oq_cnt == `RSQ_QDEPTH);

  // flow characters: request stands while the fill level holds, until the transmitter takes it
  always_comb begin : flow_req
    ser_tx_valid = 1'b0;
    ser_tx_char = `RSQ_CH_XOFF;
    if (!st_reg.xoff_sent && st_reg.ib_cnt >= `RSQ_XOFF_LVL) begin
      ser_tx_valid = 1'b1;
    end else if (st_reg.xoff_sent && st_reg.ib_cnt < `RSQ_XON_LVL) begin
      ser_tx_valid = 1'b1;
      ser_tx_char = `RSQ_CH_XON;
    end
  end

  // ----------------------------------------------------------------
  // apb decode; zero wait states, unmapped answers with pslverr
  // ----------------------------------------------------------------
  assign acc = apb_i.psel & apb_i.penable;
  assign wcmd = apb_i.pwdata;
  always_comb begin : apb_read
    apb_o.pready = 1'b1;
    apb_o.pslverr = 1'b0;
    apb_o.prdata = 32'h0000_0000;
    rd_esr = 1'b0;
    rd_fault = 1'b0;
    rd_inbuf = 1'b0;
    wr_cmd = 1'b0;
    wr_outq = 1'b0;
    if (apb_i.paddr == `RSQ_A_CMD) begin
      wr_cmd = acc & apb_i.pwrite;
    end else if (apb_i.paddr == `RSQ_A_ESR) begin
      apb_o.prdata = {16'h0000, st_reg.esr};
      rd_esr = acc & ~apb_i.pwrite;
    end else if (apb_i.paddr == `RSQ_A_ESE) begin
      apb_o.prdata = {24'h00_0000, st_reg.ese};
    end else if (apb_i.paddr == `RSQ_A_SRE) begin
      apb_o.prdata = {24'h00_0000, st_reg.sre};
    end else if (apb_i.paddr == `RSQ_A_STB) begin
      apb_o.prdata = {24'h00_0000, stb_o};
    end else if (apb_i.paddr == `RSQ_A_FAULT) begin
      // empty queue reads as code zero
      if (st_reg.eq_cnt != 5'h00) begin
        apb_o.prdata = {16'h0000, st_reg.eq[0]};
      end
      rd_fault = acc & ~apb_i.pwrite;
    end else if (apb_i.paddr == `RSQ_A_OUTQ) begin
      apb_o.prdata = {24'h00_0000, st_reg.oq_cnt};
      wr_outq = acc & apb_i.pwrite;
    end else if (apb_i.paddr == `RSQ_A_INBUF) begin
      apb_o.prdata = {22'h00_0000, (st_reg.ib_cnt != 8'h00), st_reg.ib[st_reg.ib_rd]};
      rd_inbuf = acc & ~apb_i.pwrite;
    end else if (apb_i.paddr == `RSQ_A_STAT) begin
      apb_o.prdata = {16'h0000, st_reg.ib_cnt, 3'h0, st_reg.rstate, st_reg.opc_pend,
                      st_reg.opcq_pend, st_reg.wai_pend, st_reg.rst_pend};
    end else begin
      apb_o.pslverr = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin : next_state
    st_next = st_reg;
    ev = 16'h0000;
    pw = pow10(st_reg.ridx);
    any_clr = wr_cmd & (wcmd[`RSQ_C_CLS] | wcmd[`RSQ_C_RST]);
    // clear only what was shown, so a same-cycle event survives
    esr_clr = rd_esr ? st_reg.esr : 16'h0000;
    if (any_clr || dev_clear) begin
      esr_clr = 16'hFFFF;
    end

    // error reports set their class bit
    if (err_valid) begin
      if (err_class == `RSQ_CL_CME) begin
        ev[`RSQ_E_CME] = 1'b1;
      end else if (err_class == `RSQ_CL_EXE) begin
        ev[`RSQ_E_EXE] = 1'b1;
      end else begin
        ev[`RSQ_E_DDE] = 1'b1;
      end
    end
    // host tried to read with nothing queued
    if (out_ready && !mav) begin
      ev[`RSQ_E_QYE] = 1'b1;
    end

    // enable masks
    if (acc && apb_i.pwrite && apb_i.paddr == `RSQ_A_ESE) begin
      st_next.ese = wcmd[7:0];
    end
    if (acc && apb_i.pwrite && apb_i.paddr == `RSQ_A_SRE) begin
      st_next.sre = wcmd[7:0];
    end

    // pending completion commands; a new one in the clearing write survives
    if (any_clr) begin
      st_next.opc_pend = 1'b0;
      st_next.opcq_pend = 1'b0;
    end
    opcq_fire = st_reg.opcq_pend & ~ops_busy & ~oq_full;
    if (st_reg.opc_pend && !ops_busy) begin
      ev[`RSQ_E_OPC] = 1'b1;
      st_next.opc_pend = 1'b0;
    end
    if (opcq_fire) begin
      st_next.opcq_pend = 1'b0;
    end
    if (st_reg.wai_pend && !ops_busy) begin
      st_next.wai_pend = 1'b0;
    end
    if (st_reg.rst_pend && rst_done) begin
      st_next.rst_pend = 1'b0;
    end
    if (wr_cmd) begin
      if (wcmd[`RSQ_C_OPC]) st_next.opc_pend = 1'b1;
      if (wcmd[`RSQ_C_OPCQ]) st_next.opcq_pend = 1'b1;
      if (wcmd[`RSQ_C_WAI]) st_next.wai_pend = 1'b1;
      if (wcmd[`RSQ_C_RST]) begin
        st_next.rst_pend = 1'b1;
        st_next.ese = 8'h00;
        st_next.sre = 8'h00;
      end
    end

    // ---- error queue: removal first, then the push sees the room left
    eq_a = st_reg.eq_cnt;
    if (rd_fault && st_reg.eq_cnt != 5'h00) begin
      for (int i = 0; i < 15; i++) begin
        st_next.eq[i] = st_reg.eq[i + 1];
      end
      eq_a = st_reg.eq_cnt - 5'h01;
    end
    if (any_clr) begin
      eq_a = 5'h00;
    end
    if (err_valid) begin
      if (eq_a < `RSQ_EQ_MAX) begin
        st_next.eq[eq_a[3:0]] = err_code;
        eq_a = eq_a + 5'h01;
      end else if (eq_a == `RSQ_EQ_MAX) begin
        st_next.eq[eq_a[3:0]] = `RSQ_ERR_OVF;
        eq_a = `RSQ_EQ_SLOTS;
      end
    end
    st_next.eq_cnt = eq_a;

    // ---- input buffer: owed terminator goes in before any new byte
    ib_push = 1'b0;
    ib_ent = {1'b0, in_data};
    if (st_reg.eoi_pend && !ib_full) begin
      ib_push = 1'b1;
      ib_ent = {1'b1, `RSQ_CH_TERM};
      st_next.eoi_pend = 1'b0;
    end else if (in_valid && in_ready) begin
      ib_push = 1'b1;
      st_next.eoi_pend = in_eoi;
    end
    ib_pop = rd_inbuf & (st_reg.ib_cnt != 8'h00);
    if (ib_push) begin
      st_next.ib[st_reg.ib_wr] = ib_ent;
      st_next.ib_wr = (st_reg.ib_wr == `RSQ_QLAST) ? 8'h00 : st_reg.ib_wr + 8'h01;
    end
    if (ib_pop) begin
      st_next.ib_rd = (st_reg.ib_rd == `RSQ_QLAST) ? 8'h00 : st_reg.ib_rd + 8'h01;
    end
    st_next.ib_cnt = st_reg.ib_cnt + {7'h00, ib_push} - {7'h00, ib_pop};
    // device clear wins over a byte arriving in the same cycle
    if (dev_clear) begin
      st_next.ib_rd = 8'h00;
      st_next.ib_wr = 8'h00;
      st_next.ib_cnt = 8'h00;
      st_next.eoi_pend = 1'b0;
    end
    if (ser_tx_valid && ser_tx_ready) begin
      st_next.xoff_sent = ~st_reg.xoff_sent;
    end

    // ---- decimal renderer; stalls while the output queue is full
    oq_push = 1'b0;
    oq_ch = `RSQ_CH_ONE;
    if (opcq_fire) begin
      oq_push = 1'b1;
    end
    case (st_reg.rstate)
      RSQ_R_IDLE: begin
        if (wr_cmd && wcmd[`RSQ_C_QHI:`RSQ_C_QLO] != 3'h0) begin
          st_next.rstate = RSQ_R_RUN;
          st_next.ridx = 3'h0;
          st_next.rdig = 4'h0;
          st_next.rstart = 1'b0;
          if (wcmd[`RSQ_C_QHI:`RSQ_C_QLO] == `RSQ_Q_ESR) begin
            st_next.rval = st_reg.esr;
            esr_clr = st_reg.esr;
          end else if (wcmd[`RSQ_C_QHI:`RSQ_C_QLO] == `RSQ_Q_ESE) begin
            st_next.rval = {8'h00, st_reg.ese};
          end else if (wcmd[`RSQ_C_QHI:`RSQ_C_QLO] == `RSQ_Q_SRE) begin
            st_next.rval = {8'h00, st_reg.sre};
          end else begin
            st_next.rval = {8'h00, stb_o};
          end
        end
      end
      RSQ_R_RUN: begin
        if (st_reg.rval >= pw) begin
          st_next.rval = st_reg.rval - pw;
          st_next.rdig = st_reg.rdig + 4'h1;
        end else if (st_reg.rstart || st_reg.rdig != 4'h0 || st_reg.ridx == `RSQ_DIG_LAST) begin
          // leading zeros are skipped, a lone zero is still sent
          if (!oq_full && !opcq_fire) begin
            oq_push = 1'b1;
            oq_ch = {4'h3, st_reg.rdig};
            st_next.rstart = 1'b1;
            st_next.rdig = 4'h0;
            st_next.ridx = st_reg.ridx + 3'h1;
            if (st_reg.ridx == `RSQ_DIG_LAST) st_next.rstate = RSQ_R_IDLE;
          end
        end else begin
          st_next.ridx = st_reg.ridx + 3'h1;
        end
      end
      default: st_next.rstate = RSQ_R_IDLE;
    endcase
    // firmware characters only go in when nothing else pushes
    if (!oq_push && wr_outq && !oq_full) begin
      oq_push = 1'b1;
      oq_ch = wcmd[7:0];
    end

    // ---- output queue
    oq_pop = mav & out_ready;
    if (oq_push) begin
      st_next.oq[st_reg.oq_wr] = oq_ch;
      st_next.oq_wr = (st_reg.oq_wr == `RSQ_QLAST) ? 8'h00 : st_reg.oq_wr + 8'h01;
    end
    if (oq_pop) begin
      st_next.oq_rd = (st_reg.oq_rd == `RSQ_QLAST) ? 8'h00 : st_reg.oq_rd + 8'h01;
    end
    st_next.oq_cnt = st_reg.oq_cnt + {7'h00, oq_push} - {7'h00, oq_pop};
    if (wr_cmd && wcmd[`RSQ_C_RST]) begin
      st_next.oq_rd = 8'h00;
      st_next.oq_wr = 8'h00;
      st_next.oq_cnt = 8'h00;
    end

    // ---- status register: events win over clears
    st_next.esr = (st_reg.esr & ~esr_clr) | ev;

    // ---- request bit: set on a rising summary, cleared by poll, clear or a low summary
    st_next.mss_q = mss;
    if (mss && !st_reg.mss_q) begin
      st_next.rqs = 1'b1;
    end else if (spoll || any_clr || !mss) begin
      st_next.rqs = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register; power-up empties every queue
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin : state_ff
    if (!presetn) begin
      st_reg <= '0;
      st_reg.esr <= `RSQ_ESR_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence fault_pop_s;
    rd_fault && st_reg.eq_cnt != 5'h00 && !err_valid && !any_clr;
  endsequence

  esr_read_clr_a: assert property (rd_esr && !err_valid && !out_ready && !st_reg.opc_pend
    && !wr_cmd |=> st_reg.esr == 16'h0000) else $error("status not cleared by read");
  mav_track_a: assert property (st_reg.oq_cnt == 8'h01 && out_ready && !oq_push
    |=> !stb_o[`RSQ_S_MAV]) else $error("message bit left after last read");
  oq_bound_a: assert property (st_reg.oq_cnt <= `RSQ_QDEPTH)
    else $error("output queue over size");
  fault_pop_a: assert property (fault_pop_s |=> st_reg.eq_cnt == $past(st_reg.eq_cnt) - 5'h01)
    else $error("fetch did not remove entry");
  fault_zero_a: assert property (st_reg.eq_cnt == 5'h00 && apb_i.paddr == `RSQ_A_FAULT
    |-> apb_o.prdata == 32'h0000_0000) else $error("empty fetch not zero");
  eq_ovf_a: assert property (st_reg.eq_cnt == `RSQ_EQ_MAX && err_valid && !rd_fault && !any_clr
    |=> st_reg.eq_cnt == `RSQ_EQ_SLOTS && st_reg.eq[15] == `RSQ_ERR_OVF)
    else $error("overflow entry missing");
  eq_drop_a: assert property (st_reg.eq_cnt == `RSQ_EQ_SLOTS && !rd_fault && !any_clr
    |=> st_reg.eq_cnt == `RSQ_EQ_SLOTS) else $error("full error queue changed");
  nrfd_full_a: assert property (nrfd == (st_reg.ib_cnt == `RSQ_QDEPTH) && !(nrfd && in_ready))
    else $error("hold-off wrong");
  dcl_empty_a: assert property (dev_clear |=> st_reg.ib_cnt == 8'h00)
    else $error("device clear left data");
  xoff_req_a: assert property (!st_reg.xoff_sent && st_reg.ib_cnt >= `RSQ_XOFF_LVL
    |-> ser_tx_valid && ser_tx_char == `RSQ_CH_XOFF) else $error("no Xoff");
  opc_set_a: assert property (st_reg.opc_pend && !ops_busy && !any_clr && !dev_clear
    |=> st_reg.esr[`RSQ_E_OPC]) else $error("completion bit not set");
  cme_bit_a: assert property (err_valid && err_class == `RSQ_CL_CME
    |=> st_reg.esr[`RSQ_E_CME]) else $error("command error bit missing");
  esb_sum_a: assert property (|(st_reg.esr[7:0] & st_reg.ese) |-> stb_o[`RSQ_S_ESB])
    else $error("summary bit missing");
  srq_rqs_a: assert property (mss && !st_reg.mss_q |=> srq)
    else $error("service line not raised");
  render_end_a: assert property (wr_cmd && wcmd[`RSQ_C_QHI:`RSQ_C_QLO] != 3'h0
    && st_reg.rstate == RSQ_R_IDLE && st_reg.oq_cnt == 8'h00 && !st_reg.opcq_pend
    |-> ##[1:60] st_reg.rstate == RSQ_R_IDLE) else $error("render did not finish");
endmodule : rsq_top
`default_nettype wire

// *** logic/rsq_regs.svh ***
// Purpose: offsets, field positions, reset values and levels of the status/queue block
// Assumes: 32-bit APB, one word per register
// Notes: included by the package and the bench top module
`ifndef RSQ_REGS_SVH
`define RSQ_REGS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define RSQ_A_CMD 32'h0000_0000
`define RSQ_A_ESR 32'h0000_0004
`define RSQ_A_ESE 32'h0000_0008
`define RSQ_A_SRE 32'h0000_000C
`define RSQ_A_STB 32'h0000_0010
`define RSQ_A_FAULT 32'h0000_0014
`define RSQ_A_OUTQ 32'h0000_0018
`define RSQ_A_INBUF 32'h0000_001C
`define RSQ_A_STAT 32'h0000_0020

// ----------------------------------------------------------------
// command word bits
// ----------------------------------------------------------------
`define RSQ_C_CLS 0
`define RSQ_C_OPC 1
`define RSQ_C_OPCQ 2
`define RSQ_C_WAI 3
`define RSQ_C_RST 4
`define RSQ_C_QLO 8
`define RSQ_C_QHI 10
`define RSQ_Q_ESR 3'h1
`define RSQ_Q_ESE 3'h2
`define RSQ_Q_SRE 3'h3
`define RSQ_Q_STB 3'h4

// ----------------------------------------------------------------
// event status and status byte fields
// ----------------------------------------------------------------
`define RSQ_E_OPC 0
`define RSQ_E_QYE 2
`define RSQ_E_DDE 3
`define RSQ_E_EXE 4
`define RSQ_E_CME 5
`define RSQ_ESR_RST 16'h0080
`define RSQ_S_MAV 4
`define RSQ_S_ESB 5
`define RSQ_S_RQS 6
`define RSQ_CL_CME 2'h0
`define RSQ_CL_EXE 2'h1
`define RSQ_CL_DDE 2'h2

// ----------------------------------------------------------------
// queue sizes, flow levels and characters
// ----------------------------------------------------------------
`define RSQ_QDEPTH 8'hFA
`define RSQ_QLAST 8'hF9
`define RSQ_XOFF_LVL 8'hC8
`define RSQ_XON_LVL 8'h64
`define RSQ_EQ_MAX 5'h0F
`define RSQ_EQ_SLOTS 5'h10
`define RSQ_ERR_OVF 16'h0001
`define RSQ_CH_XON 8'h11
`define RSQ_CH_XOFF 8'h13
`define RSQ_CH_ONE 8'h31
`define RSQ_CH_TERM 8'h0A
`define RSQ_DIG_LAST 3'h4

`endif

// *** logic/rsq_pkg.sv ***
// Purpose: types of the remote status and queue block
// Assumes: rsq_regs.svh holds every number
// Notes: all state of the top module is one packed struct
`default_nettype none
package rsq_pkg;
  `include "rsq_regs.svh"

  // ----------------------------------------------------------------
  // bus carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } rsq_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rsq_apb_rsp_t;

  // decimal renderer states
  typedef enum logic [0:0] {
    RSQ_R_IDLE = 1'b0,
    RSQ_R_RUN = 1'b1
  } rsq_rstate_t;

  // ----------------------------------------------------------------
  // whole module state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [249:0][8:0] ib; // input buffer entries, bit 8 marks a terminator
    logic [7:0] ib_rd;
    logic [7:0] ib_wr;
    logic [7:0] ib_cnt;
    logic eoi_pend; // terminator entry still owed
    logic xoff_sent;
    logic [249:0][7:0] oq; // output queue characters
    logic [7:0] oq_rd;
    logic [7:0] oq_wr;
    logic [7:0] oq_cnt;
    logic [15:0][15:0] eq; // error queue, front at index 0
    logic [4:0] eq_cnt;
    logic [15:0] esr;
    logic [7:0] ese;
    logic [7:0] sre;
    logic rqs;
    logic mss_q;
    logic opc_pend;
    logic opcq_pend;
    logic wai_pend;
    logic rst_pend;
    rsq_rstate_t rstate;
    logic [15:0] rval;
    logic [2:0] ridx;
    logic [3:0] rdig;
    logic rstart;
  } rsq_st_t;
endpackage : rsq_pkg
`default_nettype wire

// *** bench/rsq_host_model.sv ***
// Purpose: controller at the far side of the input link
// Assumes: bytes count up from 0, one byte per handshake
// Notes: serial mode obeys Xoff/Xon, bus mode waits on in_ready only
`default_nettype none
module rsq_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go, // load a burst of n bytes
  input wire logic [8:0] n,
  input wire logic serial, // obey flow characters
  input wire logic in_ready,
  input wire logic ser_tx_valid,
  input wire logic [7:0] ser_tx_char,
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_eoi,
  output logic ser_tx_ready,
  output logic [8:0] left // bytes still owed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic paused; // between Xoff and Xon
  logic [7:0] k; // next byte value
  // slow transmitter: accepts a flow character one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= '0;
      k <= '0;
      paused <= 1'b0;
      ser_tx_ready <= 1'b0;
    end else begin
      ser_tx_ready <= ser_tx_valid & ~ser_tx_ready;
      if (ser_tx_valid && ser_tx_ready) begin
        paused <= (ser_tx_char == 8'h13);
      end
      if (go) begin
        left <= n;
      end else if (in_valid && in_ready) begin
        left <= left - 9'd1;
        k <= k + 8'd1;
      end
    end
  end
  // a byte stays offered until taken or paused by Xoff; released data shows the inverse
  assign in_valid = (left != 9'd0) && !(serial && paused);
  assign in_data = in_valid ? k : ~k;
  assign in_eoi = in_valid && (left == 9'd1);
endmodule // rsq_host_model
`default_nettype wire

// *** bench/rsq_top_tb_top.sv ***
// Purpose: self-checking bench of the status and queue block
// Assumes: zero-wait APB, host model on the input link
// Notes: expected values are literals; register map constants give addresses and bit positions
`default_nettype none
`include "rsq_regs.svh"
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, a); end end
module rsq_top_tb_top;
  import rsq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  rsq_apb_req_t apb;
  rsq_apb_rsp_t apb_o;
  logic pclk, presetn, in_valid, in_eoi, in_ready, nrfd, dev_clear, ser_tx_valid;
  logic ser_tx_ready, out_valid, out_ready, err_valid, ops_busy, spoll, cmd_hold;
  logic rst_req, rst_done, srq, go, serial, er;
  logic [7:0] in_data, ser_tx_char, out_data, stb_o, c;
  logic [8:0] n, left;
  logic [15:0] err_code;
  logic [1:0] err_class;
  logic [31:0] q;
  int n_fail, comparisons;
  rsq_top dut (.pclk, .presetn, .apb_i(apb), .apb_o, .in_valid, .in_data, .in_eoi,
    .in_ready, .nrfd, .dev_clear, .ser_tx_valid, .ser_tx_char, .ser_tx_ready,
    .out_valid, .out_data, .out_ready, .err_valid, .err_class, .err_code,
    .ops_busy, .spoll, .cmd_hold, .rst_req, .rst_done, .srq, .stb_o);
  rsq_host_model host (.pclk, .presetn, .go, .n, .serial, .in_ready, .ser_tx_valid,
    .ser_tx_char, .in_valid, .in_data, .in_eoi, .ser_tx_ready, .left);
  always #2.5 pclk = ~pclk;
  // one APB transfer: setup, access held until pready
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb.penable <= 1'b1;
    do @(posedge pclk); while (apb_o.pready !== 1'b1);
    q = apb_o.prdata;
    er = apb_o.pslverr;
    apb <= '0;
  endtask
  // one-cycle strobe: 0 error, 1 poll, 2 device clear, 3 host burst, 4 reset done
  task automatic pulse(input int w);
    @(posedge pclk);
    case (w)
      0: err_valid <= 1'b1;
      1: spoll <= 1'b1;
      2: dev_clear <= 1'b1;
      3: go <= 1'b1;
      default: rst_done <= 1'b1;
    endcase
    @(posedge pclk);
    {err_valid, spoll, dev_clear, go, rst_done} <= '0;
  endtask
  // the character is taken at the edge that removes it
  task automatic pop;
    @(posedge pclk);
    out_ready <= 1'b1;
    @(posedge pclk);
    c = out_data;
    out_ready <= 1'b0;
  endtask
  task automatic t_regs;
    xfer(0, `RSQ_A_ESR, 0);
    `CHK("esr power-on", 32'h80, q)
    xfer(0, `RSQ_A_ESR, 0);
    `CHK("esr after read", 32'h0, q)
    xfer(1, `RSQ_A_ESE, 32'hA5);
    xfer(0, `RSQ_A_ESE, 0);
    `CHK("ese", 32'hA5, q)
    xfer(0, `RSQ_A_ESE, 0);
    `CHK("ese reread", 32'hA5, q)
    xfer(1, `RSQ_A_SRE, 32'h20);
    xfer(0, `RSQ_A_SRE, 0);
    `CHK("sre", 32'h20, q)
    xfer(0, 32'h40, 0);
    `CHK("unmapped", 1'b1, er)
  endtask
  // render the enable mask 0xA5 as decimal text
  task automatic t_queue;
    string s = "165";
    xfer(1, `RSQ_A_CMD, 32'h200);
    for (int i = 0; i < 20; i++) begin
      xfer(0, `RSQ_A_STAT, 0);
      if (!q[4]) break;
    end
    xfer(0, `RSQ_A_OUTQ, 0);
    `CHK("queue count", 32'h3, q)
    `CHK("mav set", 1'b1, stb_o[`RSQ_S_MAV])
    for (int i = 0; i < 3; i++) begin
      pop();
      `CHK("digit", s[i], c)
    end
    @(posedge pclk);
    `CHK("out empty", 1'b0, out_valid)
    `CHK("mav clear", 1'b0, stb_o[`RSQ_S_MAV])
  endtask
  task automatic t_err;
    xfer(0, `RSQ_A_FAULT, 0);
    `CHK("fault empty", 32'h0, q)
    for (int i = 0; i < 17; i++) begin
      @(posedge pclk);
      err_code <= 16'(100 + i);
      err_class <= 2'(i % 3);
      pulse(0);
    end
    repeat (2) @(posedge pclk);
    `CHK("summary", 1'b1, stb_o[`RSQ_S_ESB])
    `CHK("srq", 1'b1, srq)
    pulse(1);
    @(posedge pclk);
    `CHK("srq polled", 1'b0, srq)
    xfer(0, `RSQ_A_ESR, 0);
    `CHK("cme", 1'b1, q[`RSQ_E_CME])
    `CHK("exe dde", 2'b11, q[`RSQ_E_EXE:`RSQ_E_DDE])
    for (int i = 0; i < 15; i++) begin
      xfer(0, `RSQ_A_FAULT, 0);
      `CHK("fault", 32'(100 + i), q)
    end
    xfer(0, `RSQ_A_FAULT, 0);
    `CHK("overflow", 32'h1, q)
    xfer(0, `RSQ_A_FAULT, 0);
    `CHK("fault drained", 32'h0, q)
    pulse(0);
    xfer(1, `RSQ_A_CMD, 32'h1);
    xfer(0, `RSQ_A_FAULT, 0);
    `CHK("fault cleared", 32'h0, q)
    `CHK("srq cleared", 1'b0, srq)
    xfer(0, `RSQ_A_ESR, 0);
    `CHK("esr cleared", 32'h0, q)
    // execution error gives status 16; rendering it must clear the register
    pulse(0);
    xfer(1, `RSQ_A_CMD, 32'h100);
    repeat (40) @(posedge pclk);
    pop();
    `CHK("esr digit", 8'h31, c)
    pop();
    `CHK("esr digit", 8'h36, c)
    xfer(0, `RSQ_A_ESR, 0);
    `CHK("esr after query", 32'h0, q)
  endtask
  task automatic t_opc;
    @(posedge pclk);
    ops_busy <= 1'b1;
    xfer(1, `RSQ_A_CMD, 32'hE);
    repeat (2) @(posedge pclk);
    `CHK("hold", 1'b1, cmd_hold)
    `CHK("no answer yet", 1'b0, out_valid)
    xfer(0, `RSQ_A_ESR, 0);
    `CHK("opc early", 1'b0, q[0])
    ops_busy <= 1'b0;
    xfer(0, `RSQ_A_ESR, 0);
    `CHK("opc done", 1'b1, q[0])
    `CHK("hold released", 1'b0, cmd_hold)
    pop();
    `CHK("opc answer", 8'h31, c)
    xfer(1, `RSQ_A_CMD, 32'h10);
    @(posedge pclk);
    `CHK("reset busy", 1'b1, rst_req & cmd_hold)
    pulse(4);
    xfer(0, `RSQ_A_ESE, 0);
    `CHK("ese after reset", 32'h0, q)
    `CHK("reset done", 1'b0, rst_req)
  endtask
  task automatic t_inbuf;
    serial <= 1'b1;
    n <= 9'd250;
    pulse(3);
    for (int i = 0; i < 600 && !(left != 0 && !in_valid); i++) @(posedge pclk);
    xfer(0, `RSQ_A_STAT, 0);
    `CHK("xoff level", 1'b1, q[15:8] >= 8'd200 && q[15:8] < 8'd250)
    for (int i = 0; i < 110; i++) begin
      xfer(0, `RSQ_A_INBUF, 0);
      `CHK("in byte", 32'h200 | i, q)
    end
    for (int i = 0; i < 900 && left != 0; i++) @(posedge pclk);
    `CHK("xon resumed", 9'd0, left)
    pulse(2);
    xfer(0, `RSQ_A_STAT, 0);
    `CHK("cleared", 8'h0, q[15:8])
    serial <= 1'b0;
    n <= 9'd260;
    pulse(3);
    for (int i = 0; i < 600 && !nrfd; i++) @(posedge pclk);
    `CHK("nrfd full", 2'b10, {nrfd, in_ready})
    xfer(0, `RSQ_A_INBUF, 0);
    xfer(0, `RSQ_A_STAT, 0);
    `CHK("one refill", 9'd9, left)
    `CHK("full again", 8'hFA, q[15:8])
    pulse(2);
    for (int i = 0; i < 60 && left != 0; i++) @(posedge pclk);
    xfer(0, `RSQ_A_STAT, 0);
    `CHK("bytes plus mark", 8'd10, q[15:8])
  endtask
  task automatic end_sim;
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    end_sim();
  end
  initial begin
    {pclk, presetn, dev_clear, out_ready, err_valid, ops_busy, spoll} = '0;
    {rst_done, go, serial, n, err_code, err_class} = '0;
    apb = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_queue();
    t_err();
    t_opc();
    t_inbuf();
    end_sim();
  end
endmodule // rsq_top_tb_top
`default_nettype wire
